/* fault_event_source.sv */
// Event routing model that drives the two fault inputs of the PWM block.
// Assumes bench requests on i_mclk; i_lag picks 1 to 4 register stages.
`timescale 1ns/10ps
module fault_event_source (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_req_a,
  input wire logic i_req_b,
  input wire logic [1:0] i_lag,
  output logic o_event_a,
  output logic o_event_b
);
  logic [3:0] pipe_a;
  logic [3:0] pipe_b;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pipe_a <= 4'h0;
      pipe_b <= 4'h0;
    end else begin
      pipe_a <= {pipe_a[2:0], i_req_a};
      pipe_b <= {pipe_b[2:0], i_req_b};
    end
  end
  // Event channels are always driven and idle low
  assign o_event_a = pipe_a[i_lag];
  assign o_event_b = pipe_b[i_lag];
endmodule

/* pwm_fault_dither.sv */
// Fault-input action and dither sequencer for a four-segment dead-time PWM cycle.
// Assumes a classic Wishbone master on i_mclk and fault inputs from another domain.
// Overview of operation
// - Mode 9: rising edge blanks active output
// - Mode 9 leaves counter sequence untouched
// - Mode 9: input A/B only output A/B
// - Mode 10: output off while input active
// - Mode 10: released in on time, stays off
// - Mode 10: each input controls own output
// - Mode 1: end on time, wait, other dead
// - Mode 2: run other cycle, wait, own dead
// - Mode 3: repeat other cycle while active
// - Mode 5: both outputs, dead times only
// - Mode 6: end on time, run next dead, wait, other dead
// - Mode 7: stop until software restart
// - Mode 8: edge ends on time, other dead
// - Accumulate fraction, overflow inserts one cycle
// - Four dither placement choices
// - No dither in dual-slope mode
// - One-ramp: on adds one, dead adds zero
// - Two/four-ramp additions per placement table
// - Zero-add choices shorten the following state
// - Mode 0: inputs leave outputs alone
// - Mode 4: both outputs off, counter runs
// - One-ramp dead B: DEAD_TIME_B plus, ON_TIME_B minus
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
module pwm_fault_dither
  import pwm_fault_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_fault_in_a,
  input wire logic i_fault_in_b,
  output logic o_waveform_out_a,
  output logic o_waveform_out_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  cfg_s cfg;
  logic restart_cmd;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic [31:0] cur_word;
  logic bus_req;
  logic bus_wr;

  phase_e phase;
  hold_e hold;
  logic [CNT_W:0] count;
  logic [7:0] dither_acc;
  logic dith;
  logic [1:0] blocked;
  logic [1:0] pend_other;
  logic [1:0] in_meta;
  logic [1:0] in_sync;
  logic [1:0] in_prev;

  assign bus_req = i_wb_cyc & i_wb_stb;
  assign bus_wr = bus_req & i_wb_we & o_wb_ack;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    cur_word = 32'h0000_0000;
    unique case (i_wb_adr)
      OFS_CTRL: cur_word = {28'h0, 1'b0, cfg.wave, cfg.enable};
      OFS_INPUT: cur_word = {20'h0, cfg.act_b, 4'h0, cfg.act_a};
      OFS_DEAD_A: cur_word = {20'h0, cfg.dead_a};
      OFS_ON_A: cur_word = {20'h0, cfg.on_a};
      OFS_DEAD_B: cur_word = {20'h0, cfg.dead_b};
      OFS_ON_B: cur_word = {20'h0, cfg.on_b};
      OFS_DITHER: cur_word = {16'h0, cfg.dither_inc, 6'h0, cfg.dither_sel};
      default: cur_word = 32'h0000_0000;
    endcase
    wr_word = merge(cur_word, i_wb_dat, i_wb_sel);
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (i_wb_adr)
      OFS_CTRL, OFS_INPUT, OFS_DEAD_A, OFS_ON_A, OFS_DEAD_B, OFS_ON_B, OFS_DITHER:
        rd_word = cur_word;
      OFS_STATUS: rd_word = {count[CNT_W-1:0], 11'h0, dith, o_waveform_out_b, o_waveform_out_a,
                             in_sync, hold, phase};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Single-wait-state slave: ack one cycle after the request, write at the ack edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req & ~o_wb_ack;
      if (bus_req & ~o_wb_ack & ~i_wb_we) begin
        o_wb_dat <= rd_word;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= '{enable: 1'b0, wave: WAVE_ONE_RAMP, act_a: ACT_NONE, act_b: ACT_NONE,
               dead_a: RST_SEGMENT, on_a: RST_SEGMENT, dead_b: RST_SEGMENT,
               on_b: RST_SEGMENT, dither_sel: DITH_ON_B, dither_inc: RST_DITHER_INC};
      restart_cmd <= 1'b0;
    end else begin
      restart_cmd <= bus_wr && i_wb_adr == OFS_CTRL && i_wb_sel[0] &&
                     i_wb_dat[CTRL_RESTART_BIT];
      if (bus_wr) begin
        unique case (i_wb_adr)
          OFS_CTRL: begin
            cfg.enable <= wr_word[CTRL_ENABLE_BIT];
            cfg.wave <= wr_word[CTRL_WAVE_LSB +: 2];
          end
          OFS_INPUT: begin
            cfg.act_a <= wr_word[INPUT_A_LSB +: 4];
            cfg.act_b <= wr_word[INPUT_B_LSB +: 4];
          end
          OFS_DEAD_A: cfg.dead_a <= wr_word[11:0];
          OFS_ON_A: cfg.on_a <= wr_word[11:0];
          OFS_DEAD_B: cfg.dead_b <= wr_word[11:0];
          OFS_ON_B: cfg.on_b <= wr_word[11:0];
          OFS_DITHER: begin
            cfg.dither_sel <= wr_word[DITHER_SEL_LSB +: 2];
            cfg.dither_inc <= wr_word[DITHER_INC_LSB +: 8];
          end
          default: cfg.enable <= cfg.enable;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault input synchronisers and edge detect

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_meta <= 2'h0;
      in_sync <= 2'h0;
      in_prev <= 2'h0;
    end else begin
      in_meta <= {i_fault_in_b, i_fault_in_a};
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  logic [3:0] act [2];
  logic [1:0] rise;
  phase_e own_dead [2];
  phase_e own_on [2];
  phase_e opp_dead [2];

  assign act[0] = cfg.act_a;
  assign act[1] = cfg.act_b;
  assign rise = in_sync & ~in_prev;
  assign own_dead[0] = PH_DEAD_A;
  assign own_dead[1] = PH_DEAD_B;
  assign own_on[0] = PH_ON_A;
  assign own_on[1] = PH_ON_B;
  assign opp_dead[0] = PH_DEAD_B;
  assign opp_dead[1] = PH_DEAD_A;

  // Level of any input whose action mode is the given shared mode
  function automatic logic any_active(input logic [3:0] mode);
    return (in_sync[0] && act[0] == mode) || (in_sync[1] && act[1] == mode);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Segment lengths with dither

  function automatic logic [CNT_W:0] seg_len(input phase_e ph, input logic d);
    logic [CNT_W+1:0] tmp;
    logic ext;
    logic shr;
    logic short_ramp;
    tmp = '0;
    ext = 1'b0;
    shr = 1'b0;
    short_ramp = cfg.wave == WAVE_ONE_RAMP || cfg.wave == WAVE_TWO_RAMP;
    unique case (ph)
      PH_DEAD_A: tmp = {2'b00, cfg.dead_a};
      PH_ON_A: tmp = {2'b00, cfg.on_a};
      PH_DEAD_B: tmp = {2'b00, cfg.dead_b};
      PH_ON_B: tmp = {2'b00, cfg.on_b};
    endcase
    if (d) begin
      unique case (cfg.dither_sel)
        DITH_ON_B: ext = ph == PH_ON_B;
        DITH_ON_AB: begin
          ext = ph == PH_ON_A || ph == PH_ON_B;
          shr = cfg.wave == WAVE_ONE_RAMP && ph == PH_DEAD_B;
        end
        DITH_DEAD_B: begin
          ext = ph == PH_DEAD_B;
          shr = short_ramp && ph == PH_ON_B;
        end
        DITH_DEAD_AB: begin
          ext = ph == PH_DEAD_A || ph == PH_DEAD_B;
          shr = short_ramp && (ph == PH_ON_A || ph == PH_ON_B);
        end
      endcase
    end
    tmp = tmp + {{(CNT_W+1){1'b0}}, ext};
    if (shr && tmp > {{CNT_W{1'b0}}, 2'b01}) begin
      tmp = tmp - {{(CNT_W+1){1'b0}}, 1'b1};
    end
    if (tmp == '0) begin
      tmp = {{CNT_W{1'b0}}, 2'b01};
    end
    return tmp[CNT_W:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  phase_e next_phase;
  phase_e hold_target;
  phase_e next_hold_target;
  hold_e next_hold;
  logic [CNT_W:0] next_count;
  logic [1:0] next_pend_other;
  logic [1:0] next_blocked;
  logic next_dith;
  logic [8:0] acc_sum;
  logic reload;
  logic rel_busy;
  logic any_on_phase;

  assign acc_sum = {1'b0, dither_acc} + {1'b0, cfg.dither_inc};
  assign any_on_phase = phase == PH_ON_A || phase == PH_ON_B;
  assign rel_busy = (in_sync[0] && act[0] inside {ACT_STOP_JUMP_WAIT, ACT_STOP_RUN_OTHER_WAIT,
                     ACT_ALL_JUMP_WAIT}) ||
                    (in_sync[1] && act[1] inside {ACT_STOP_JUMP_WAIT, ACT_STOP_RUN_OTHER_WAIT,
                     ACT_ALL_JUMP_WAIT});

  always_comb begin
    next_phase = phase;
    next_hold = hold;
    next_hold_target = hold_target;
    next_pend_other = pend_other;
    next_dith = dith;
    reload = 1'b0;
    unique case (hold)
      HOLD_SOFTWARE: begin
        if (restart_cmd) begin
          next_hold = HOLD_NONE;
          next_phase = PH_DEAD_A;
          reload = 1'b1;
        end
      end
      HOLD_RELEASE: begin
        if (!rel_busy) begin
          next_hold = HOLD_NONE;
          next_phase = hold_target;
          reload = 1'b1;
        end
      end
      HOLD_NONE: begin
        if (count <= {{CNT_W{1'b0}}, 1'b1}) begin
          next_phase = phase_e'(phase + 2'd1);
          reload = 1'b1;
          for (int i = 0; i < 2; i++) begin
            if (phase == phase_e'(own_on[i] ^ 2'b10) && act[i] == ACT_STOP_RUN_OTHER_WAIT
                && pend_other[i]) begin
              next_pend_other[i] = 1'b0;
              if (in_sync[i]) begin
                next_hold = HOLD_RELEASE;
                next_hold_target = own_dead[i];
              end
            end
            if (phase == phase_e'(own_on[i] ^ 2'b10) && act[i] == ACT_REPEAT_OTHER
                && in_sync[i]) begin
              next_phase = opp_dead[i];
            end
          end
          if (!any_on_phase && any_active(ACT_ALL_DEAD_ONLY)) begin
            next_phase = phase_e'(phase ^ 2'b10);
          end
          if (!any_on_phase && any_active(ACT_ALL_JUMP_WAIT)) begin
            next_phase = phase;
            next_hold = HOLD_RELEASE;
            next_hold_target = phase_e'(phase ^ 2'b10);
            reload = 1'b0;
          end
        end
      end
      default: next_hold = HOLD_NONE;
    endcase
    if (hold != HOLD_SOFTWARE) begin
      for (int i = 0; i < 2; i++) begin
        unique case (act[i])
          ACT_STOP_JUMP_WAIT: begin
            if (in_sync[i] && (phase == own_dead[i] || phase == own_on[i])) begin
              next_phase = opp_dead[i];
              next_hold = HOLD_RELEASE;
              next_hold_target = opp_dead[i];
              reload = 1'b1;
            end
          end
          ACT_STOP_RUN_OTHER_WAIT: begin
            if (in_sync[i] && !pend_other[i] &&
                (phase == own_dead[i] || phase == own_on[i])) begin
              next_phase = opp_dead[i];
              next_pend_other[i] = 1'b1;
              reload = 1'b1;
            end
          end
          ACT_REPEAT_OTHER, ACT_EDGE_JUMP: begin
            if ((act[i] == ACT_REPEAT_OTHER ? in_sync[i] : rise[i]) &&
                phase == own_on[i]) begin
              next_phase = opp_dead[i];
              reload = 1'b1;
            end
          end
          ACT_ALL_DEAD_ONLY, ACT_ALL_JUMP_WAIT: begin
            if (in_sync[i] && any_on_phase && hold == HOLD_NONE) begin
              next_phase = phase_e'(phase + 2'd1);
              reload = 1'b1;
            end
          end
          ACT_ALL_SW_WAIT: begin
            if (in_sync[i]) begin
              next_hold = HOLD_SOFTWARE;
            end
          end
          default: next_pend_other[i] = next_pend_other[i];
        endcase
      end
    end
    if (reload && next_phase == PH_DEAD_A && phase == PH_ON_B) begin
      next_dith = acc_sum[8] && cfg.wave != WAVE_DUAL_SLOPE;
    end
    next_count = reload ? seg_len(next_phase, next_dith) : count - {{CNT_W{1'b0}}, 1'b1};
    if (hold != HOLD_NONE && next_hold != HOLD_NONE && !reload) begin
      next_count = count;
    end
    if (!cfg.enable) begin
      next_phase = PH_DEAD_A;
      next_hold = HOLD_NONE;
      next_pend_other = 2'b00;
      next_dith = 1'b0;
      next_count = seg_len(PH_DEAD_A, 1'b0);
    end
  end

  // Output blanking for edge and level modes; counter flow is not touched
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_blocked[i] = blocked[i] && next_phase == phase && !reload;
      if (next_phase == own_on[i] && phase == own_on[i] &&
          ((act[i] == ACT_EDGE_BLOCK && rise[i]) ||
           (act[i] == ACT_LEVEL_BLOCK && in_sync[i]))) begin
        next_blocked[i] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= PH_DEAD_A;
      hold <= HOLD_NONE;
      hold_target <= PH_DEAD_A;
      count <= {{CNT_W{1'b0}}, 1'b1};
      pend_other <= 2'b00;
      blocked <= 2'b00;
      dith <= 1'b0;
    end else begin
      phase <= next_phase;
      hold <= next_hold;
      hold_target <= next_hold_target;
      count <= next_count;
      pend_other <= next_pend_other;
      blocked <= next_blocked;
      dith <= next_dith;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dither_acc <= 8'h00;
    end else if (!cfg.enable) begin
      dither_acc <= 8'h00;
    end else if (reload && next_phase == PH_DEAD_A && phase == PH_ON_B) begin
      dither_acc <= acc_sum[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform outputs

  logic [1:0] level_off;
  logic all_off;

  assign all_off = any_active(ACT_ALL_OFF) || any_active(ACT_ALL_DEAD_ONLY) ||
                   any_active(ACT_ALL_JUMP_WAIT) || any_active(ACT_ALL_SW_WAIT);
  assign level_off[0] = act[0] == ACT_LEVEL_BLOCK && in_sync[0];
  assign level_off[1] = act[1] == ACT_LEVEL_BLOCK && in_sync[1];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_waveform_out_a <= 1'b0;
      o_waveform_out_b <= 1'b0;
    end else begin
      o_waveform_out_a <= cfg.enable && next_phase == PH_ON_A && next_hold == HOLD_NONE &&
                          !next_blocked[0] && !level_off[0] && !all_off;
      o_waveform_out_b <= cfg.enable && next_phase == PH_ON_B && next_hold == HOLD_NONE &&
                          !next_blocked[1] && !level_off[1] && !all_off;
    end
  end

endmodule

/* pwm_fault_dither_assertions.sv */
// Checker for the fault-input and dither block, watching its ports only.
// Assumes register writes land at the acknowledging edge of a classic bus cycle.
`timescale 1ns/10ps
module pwm_fault_dither_assertions
  import pwm_fault_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_fault_in_a,
  input wire logic i_fault_in_b,
  input wire logic o_waveform_out_a,
  input wire logic o_waveform_out_b
);
  logic [3:0] mode_a, mode_b;
  logic en;
  logic [1:0] wave;
  logic [2:0] hist_a, hist_b;
  logic sw_hold;
  logic [5:0] dual_age;
  logic wr_ok;
  assign wr_ok = o_wb_ack && i_wb_we && i_wb_sel[0];
  ////////////////////////////////////////
  // Shadow copies of the mode and control fields
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_a <= ACT_NONE;
      mode_b <= ACT_NONE;
    end else if (o_wb_ack && i_wb_we && i_wb_adr == OFS_INPUT) begin
      mode_a <= i_wb_sel[0] ? i_wb_dat[3:0] : mode_a;
      mode_b <= i_wb_sel[1] ? i_wb_dat[11:8] : mode_b;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en <= 1'b0;
      wave <= WAVE_ONE_RAMP;
    end else if (wr_ok && i_wb_adr == OFS_CTRL) begin
      en <= i_wb_dat[CTRL_ENABLE_BIT];
      wave <= i_wb_dat[2:1];
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_a <= 3'h0;
      hist_b <= 3'h0;
    end else begin
      hist_a <= {hist_a[1:0], i_fault_in_a};
      hist_b <= {hist_b[1:0], i_fault_in_b};
    end
  end
  // Held by a mode 7 event until a restart is written
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_hold <= 1'b0;
    end else if ((mode_a == ACT_ALL_SW_WAIT && hist_a == 3'h7)
                 || (mode_b == ACT_ALL_SW_WAIT && hist_b == 3'h7)) begin
      sw_hold <= 1'b1;
    end else if (wr_ok && i_wb_adr == OFS_CTRL && i_wb_dat[CTRL_RESTART_BIT]) begin
      sw_hold <= 1'b0;
    end
  end
  // Lets a dithered cycle begun before the switch run out
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dual_age <= 6'h00;
    end else if (wave != WAVE_DUAL_SLOPE) begin
      dual_age <= 6'h00;
    end else if (dual_age != 6'h3F) begin
      dual_age <= dual_age + 6'h01;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_mode4_blank: assert property (
    (mode_a == ACT_ALL_OFF && i_fault_in_a) [*3] |=> !o_waveform_out_a && !o_waveform_out_b)
    else $error("output on under stop all");
  a_level_block_a: assert property (
    (mode_a == ACT_LEVEL_BLOCK && i_fault_in_a) [*3] |=> !o_waveform_out_a)
    else $error("output a on while level block active");
  a_level_block_b: assert property (
    (mode_b == ACT_LEVEL_BLOCK && i_fault_in_b) [*3] |=> !o_waveform_out_b)
    else $error("output b on while level block active");
  a_edge_block: assert property (
    (mode_a == ACT_EDGE_BLOCK && o_waveform_out_a && $rose(i_fault_in_a)) ##1
    i_fault_in_a [*3] |=> !o_waveform_out_a)
    else $error("output a not blanked after edge");
  a_sw_hold: assert property (sw_hold |-> !o_waveform_out_a && !o_waveform_out_b)
    else $error("output on awaiting restart");
  a_disabled_quiet: assert property ((!en) [*3] |-> !o_waveform_out_a && !o_waveform_out_b)
    else $error("output on while timer disabled");
  a_no_dual_dither: assert property (
    o_wb_ack && !i_wb_we && i_wb_adr == OFS_STATUS && dual_age == 6'h3F |-> !o_wb_dat[8])
    else $error("dither applied in dual slope");
  a_unmapped_zero: assert property (
    o_wb_ack && !i_wb_we && i_wb_adr > OFS_STATUS |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  c_mode4: cover property ((mode_a == ACT_ALL_OFF && i_fault_in_a) [*3]);
  c_edge: cover property (mode_a == ACT_EDGE_BLOCK && o_waveform_out_a && $rose(i_fault_in_a));
  c_hold: cover property (sw_hold);
endmodule

/* pwm_fault_dither_test.sv */
// Self-checking bench for the fault-input and dither block.
// Assumes the event model and checker are compiled first.
`timescale 1ns/10ps
module pwm_fault_dither_test;
  import pwm_fault_pkg::*;
  localparam logic [11:0] DEAD = 12'h002;
  localparam logic [11:0] ON = 12'h006;
  localparam int PER = 16;
  typedef struct packed {
    logic [1:0] wave;
    logic [1:0] place;
    logic [1:0] extra;
  } dither_row_s;
  dither_row_s rows [12] = '{
    '{WAVE_ONE_RAMP, DITH_ON_B, 2'h1}, '{WAVE_ONE_RAMP, DITH_ON_AB, 2'h1},
    '{WAVE_ONE_RAMP, DITH_DEAD_B, 2'h0}, '{WAVE_ONE_RAMP, DITH_DEAD_AB, 2'h0},
    '{WAVE_TWO_RAMP, DITH_ON_B, 2'h1}, '{WAVE_TWO_RAMP, DITH_ON_AB, 2'h2},
    '{WAVE_TWO_RAMP, DITH_DEAD_B, 2'h0}, '{WAVE_TWO_RAMP, DITH_DEAD_AB, 2'h0},
    '{WAVE_FOUR_RAMP, DITH_ON_B, 2'h1}, '{WAVE_FOUR_RAMP, DITH_ON_AB, 2'h2},
    '{WAVE_FOUR_RAMP, DITH_DEAD_B, 2'h1}, '{WAVE_FOUR_RAMP, DITH_DEAD_AB, 2'h2}};
  logic mclk, rst_n, cyc, stb, we, ack, fault_a, fault_b, out_a, out_b, req_a, req_b;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [1:0] lag;
  int n_errors = 0;
  int n_tests = 0;
  pwm_fault_dither i_pwm_fault_dither (.i_mclk(mclk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_fault_in_a(fault_a), .i_fault_in_b(fault_b),
    .o_waveform_out_a(out_a), .o_waveform_out_b(out_b));
  fault_event_source i_fault_event_source (.i_mclk(mclk), .i_rst_n(rst_n), .i_req_a(req_a),
    .i_req_b(req_b), .i_lag(lag), .o_event_a(fault_a), .o_event_b(fault_b));
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic cfg_len();
    for (int i = 0; i < 4; i++) begin
      wr(8'(OFS_DEAD_A + 4 * i), {20'h0, i[0] ? ON : DEAD});
    end
  endtask
  // Cycles from one rising edge of the chosen output to the n-th after it
  task automatic span(input bit use_b, input int n, output int c);
    int k;
    logic p, s;
    k = -1;
    c = 0;
    p = 1'b1;
    while (k < n) begin
      @(posedge mclk);
      s = use_b ? out_b : out_a;
      if (k >= 0) c++;
      if (s === 1'b1 && p !== 1'b1) k++;
      p = s;
    end
  endtask
  task automatic count_on(input int n, output int na, output int nb);
    na = 0;
    nb = 0;
    repeat (n) begin
      @(posedge mclk);
      na += int'(out_a === 1'b1);
      nb += int'(out_b === 1'b1);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("timeout");
    summarize();
  end
  initial begin
    int c, na, nb;
    logic [31:0] q;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    req_a = 1'b0;
    req_b = 1'b0;
    lag = 2'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    cfg_len();
    // Inputs held active in mode 0 must change nothing
    req_a <= 1'b1;
    req_b <= 1'b1;
    foreach (rows[i]) begin
      wr(OFS_CTRL, {29'h0, rows[i].wave, 1'b1});
      wr(OFS_DITHER, {16'h0, 8'h80, 6'h0, rows[i].place});
      span(1'b0, 2, c);
      span(1'b0, 2, c);
      check("dither period pair", 32'(c), 32'(2 * PER + rows[i].extra));
      if (rows[i].extra == 2'h0) begin
        count_on(2 * PER, na, nb);
        check("shortened on time b", 32'(nb), 32'(2 * ON - 1));
      end
    end
    wr(OFS_CTRL, {29'h0, WAVE_DUAL_SLOPE, 1'b1});
    repeat (70) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, OFS_STATUS, 32'h0, q);
      check("dither flag in dual slope", {31'h0, q[8]}, 32'h0);
    end
    // Reset in mid-run, then the register defaults and an unmapped place
    req_a <= 1'b0;
    req_b <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    check("outputs in reset", {30'h0, out_a, out_b}, 32'h0);
    rst_n <= 1'b1;
    wr(8'h20, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, (i == 7) ? 8'h20 : 8'(4 * i), 32'h0, q);
      check("reset value", q, (i >= 2 && i <= 5) ? {20'h0, RST_SEGMENT} : 32'h0);
    end
    cfg_len();
    wr(OFS_INPUT, {20'h0, ACT_NONE, 4'h0, ACT_ALL_OFF});
    wr(OFS_CTRL, 32'h1);
    req_a <= 1'b1;
    repeat (6) @(posedge mclk);
    count_on(3 * PER, na, nb);
    check("highs under stop all", 32'(na + nb), 32'h0);
    req_a <= 1'b0;
    span(1'b1, 1, c);
    check("period after stop all", 32'(c), 32'(PER));
    wr(OFS_INPUT, {20'h0, ACT_LEVEL_BLOCK, 4'h0, ACT_NONE});
    lag <= 2'h2;
    req_b <= 1'b1;
    repeat (8) @(posedge mclk);
    count_on(3 * PER, na, nb);
    check("level block b highs", 32'(nb), 32'h0);
    check("level block a highs", 32'(na), 32'(3 * ON));
    req_b <= 1'b0;
    lag <= 2'h0;
    wr(OFS_INPUT, {20'h0, ACT_NONE, 4'h0, ACT_EDGE_BLOCK});
    span(1'b0, 0, c);
    req_a <= 1'b1;
    span(1'b1, 2, c);
    check("edge block b period pair", 32'(c), 32'(2 * PER));
    req_a <= 1'b0;
    wr(OFS_INPUT, {20'h0, ACT_ALL_SW_WAIT, 4'h0, ACT_NONE});
    req_b <= 1'b1;
    repeat (5) @(posedge mclk);
    req_b <= 1'b0;
    repeat (6) @(posedge mclk);
    count_on(3 * PER, na, nb);
    check("highs while held", 32'(na + nb), 32'h0);
    wr(OFS_CTRL, 32'h9);
    span(1'b0, 1, c);
    check("period after restart", 32'(c), 32'(PER));
    summarize();
  end
endmodule

bind pwm_fault_dither pwm_fault_dither_assertions i_pwm_fault_dither_assertions (.*);

/* pwm_fault_pkg.sv */
// Package for the fault-input and dither block of the dead-time PWM timer.
// Assumes a 32-bit classic Wishbone bus with byte addresses, one word per register.
package pwm_fault_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INPUT = 8'h04;
  localparam logic [7:0] OFS_DEAD_A = 8'h08;
  localparam logic [7:0] OFS_ON_A = 8'h0C;
  localparam logic [7:0] OFS_DEAD_B = 8'h10;
  localparam logic [7:0] OFS_ON_B = 8'h14;
  localparam logic [7:0] OFS_DITHER = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_WAVE_LSB = 1;
  localparam int CTRL_RESTART_BIT = 3;
  localparam int INPUT_A_LSB = 0;
  localparam int INPUT_B_LSB = 8;
  localparam int DITHER_SEL_LSB = 0;
  localparam int DITHER_INC_LSB = 8;

  // Values after reset
  localparam logic [11:0] RST_SEGMENT = 12'h010;
  localparam logic [7:0] RST_DITHER_INC = 8'h00;

  // Waveform generation modes
  localparam logic [1:0] WAVE_ONE_RAMP = 2'h0;
  localparam logic [1:0] WAVE_TWO_RAMP = 2'h1;
  localparam logic [1:0] WAVE_FOUR_RAMP = 2'h2;
  localparam logic [1:0] WAVE_DUAL_SLOPE = 2'h3;

  // Dither placement choices
  localparam logic [1:0] DITH_ON_B = 2'h0;
  localparam logic [1:0] DITH_ON_AB = 2'h1;
  localparam logic [1:0] DITH_DEAD_B = 2'h2;
  localparam logic [1:0] DITH_DEAD_AB = 2'h3;

  // Fault input action modes
  localparam logic [3:0] ACT_NONE = 4'h0;
  localparam logic [3:0] ACT_STOP_JUMP_WAIT = 4'h1;
  localparam logic [3:0] ACT_STOP_RUN_OTHER_WAIT = 4'h2;
  localparam logic [3:0] ACT_REPEAT_OTHER = 4'h3;
  localparam logic [3:0] ACT_ALL_OFF = 4'h4;
  localparam logic [3:0] ACT_ALL_DEAD_ONLY = 4'h5;
  localparam logic [3:0] ACT_ALL_JUMP_WAIT = 4'h6;
  localparam logic [3:0] ACT_ALL_SW_WAIT = 4'h7;
  localparam logic [3:0] ACT_EDGE_JUMP = 4'h8;
  localparam logic [3:0] ACT_EDGE_BLOCK = 4'h9;
  localparam logic [3:0] ACT_LEVEL_BLOCK = 4'hA;

  typedef enum logic [1:0] {PH_DEAD_A, PH_ON_A, PH_DEAD_B, PH_ON_B} phase_e;
  typedef enum logic [1:0] {HOLD_NONE, HOLD_RELEASE, HOLD_SOFTWARE} hold_e;

  typedef struct packed {
    logic enable;
    logic [1:0] wave;
    logic [3:0] act_a;
    logic [3:0] act_b;
    logic [11:0] dead_a;
    logic [11:0] on_a;
    logic [11:0] dead_b;
    logic [11:0] on_b;
    logic [1:0] dither_sel;
    logic [7:0] dither_inc;
  } cfg_s;

endpackage
